// ### inc/dma_mode_pkg.sv
// Constants and types for the DMA mode and wait-state control block.
package dma_mode_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] MODE_ADDR   = 8'h31;
  localparam logic [7:0] CTRL_ADDR   = 8'h32;
  localparam logic [7:0] ENABLE_ADDR = 8'h33;
  localparam logic [7:0] COUNT0_ADDR = 8'h34;
  localparam logic [7:0] COUNT1_ADDR = 8'h35;

  // Field positions in the channel 0 mode register.
  localparam int DST_LSB    = 4;
  localparam int SRC_LSB    = 2;
  localparam int TIMING_BIT = 1;

  // Field positions in the wait and request control register.
  localparam int MEMWAIT_LSB = 6;
  localparam int IOWAIT_LSB  = 4;
  localparam int SENSE_LSB   = 2;
  localparam int DIR_LSB     = 0;

  // Field positions in the enable register.
  localparam int EN0_BIT = 0;
  localparam int EN1_BIT = 1;

  // Values after reset.
  localparam logic [1:0] MODE_FIELD_RESET = 2'h0;
  localparam logic [1:0] WAIT_RESET       = 2'h3;
  localparam logic [7:0] COUNT_RESET      = 8'h00;

  // Address selector code that means an I/O port with fixed address.
  localparam logic [1:0] SEL_IO_FIXED = 2'h3;

  // Cycle counts: base length of one byte transfer and of one machine cycle.
  localparam logic [3:0] BYTE_BASE_CYCLES = 4'h3;
  localparam logic [3:0] MACHINE_CYCLES   = 4'h3;

  // Sequencer states, Gray coded along idle, move, steal.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_MOVE  = 2'b01,
    ST_STEAL = 2'b11
  } seq_type;

  // Stored configuration, driven out as one bundle.
  typedef struct packed {
    logic [1:0] ch0DestinationSelect;
    logic [1:0] ch0SourceSelect;
    logic       memcopyTimingSelect;
    logic [1:0] memoryWaitCount;
    logic [1:0] ioWaitCount;
    logic [1:0] requestSenseSelect;
    logic [1:0] ch1DirectionSelect;
  } cfg_type;

endpackage : dma_mode_pkg

// ### rtl/dma_mode_and_wait_control.sv
// Channel mode, wait-state and request-sense control of a two-channel DMA engine.
`timescale 1ns/1ps

// Function
// - Destination code picks target type and stepping.
// - Source code picks source type and stepping.
// - Fixed-to-fixed and I/O-to-I/O codes are reserved.
// - Memory copy ignores request; bit picks burst.
// - Burst holds bus until count reaches zero.
// - Cycle steal returns bus after each byte.
// - I/O channel 0 paced by request, timing ignored.
// - Memory wait field sets waits, reset ones.
// - I/O wait field sets waits, reset ones.
// - Per-channel sense bit: zero level, one edge.
// - Channel 1 direction and stepping from field.
// - Channel 1 moves only between memory and I/O.
// - Level sense: run while request sampled low.
// - Edge sense: continue only on fresh falling edge.
// - Zero count clears the channel enable bit.
module dma_mode_and_wait_control
  import dma_mode_pkg::*;
(
  // Clock and synchronous reset.
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Register port.
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // Request pins, active low, asynchronous to clk_sys.
  input  wire logic       ch0RequestIn_n,
  input  wire logic       ch1RequestIn_n,
  // Configuration and sequencer status.
  output cfg_type         cfg,
  output logic            busHold,
  output logic            byteDone,
  output logic            activeChannel,
  output logic            reservedMode
);

  seq_type    state;           // Sequencer state.
  seq_type    next_state;      // Sequencer state for the next cycle.
  logic       next_channel;    // Channel served in the next cycle.
  logic       nextByte;        // A new byte transfer starts next cycle.
  logic       byteEnd;         // Last cycle of the current byte.
  logic       lastByte;        // Current byte is the final one.
  logic [3:0] beat;            // Cycle counter within a byte or a steal gap.
  logic [3:0] byteLen;         // Length of one byte transfer in cycles.
  logic       ch0Enable;       // Channel 0 enable bit.
  logic       ch1Enable;       // Channel 1 enable bit.
  logic [7:0] count0;          // Channel 0 byte count.
  logic [7:0] count1;          // Channel 1 byte count.
  logic [1:0] reqMeta;         // First synchroniser stage, read only by reqSync.
  logic [1:0] reqSync;         // Synchronised request pins, active low.
  logic [1:0] reqPrev;         // Previous synchronised value for edge finding.
  logic [1:0] edgePend;        // A falling edge seen since the byte began.
  logic [1:0] reqOk;           // Request condition met per channel.
  logic [1:0] reqPins;         // Raw request pins gathered by channel.
  logic       ch0Io;           // Channel 0 has an I/O end.
  logic       isReserved;      // Channel 0 code pair is reserved.
  logic       go0;             // Channel 0 may start a byte.
  logic       go1;             // Channel 1 may start a byte.
  logic       wrMode;          // Write to the mode register.
  logic       wrCtrl;          // Write to the control register.
  logic       wrEnable;        // Write to the enable register.

  assign reqPins  = {ch1RequestIn_n, ch0RequestIn_n};
  assign wrMode   = regWrite && (regAddr == MODE_ADDR);
  assign wrCtrl   = regWrite && (regAddr == CTRL_ADDR);
  assign wrEnable = regWrite && (regAddr == ENABLE_ADDR);

  assign ch0Io = (cfg.ch0DestinationSelect == SEL_IO_FIXED) ||
                 (cfg.ch0SourceSelect == SEL_IO_FIXED);
  assign isReserved = cfg.ch0DestinationSelect[1] && cfg.ch0SourceSelect[1];

  // Per-channel request synchroniser, edge catcher and sense choice.
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_req
      // Two flops before anything looks at the pin.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          reqMeta[c] <= 1'b1;
          reqSync[c] <= 1'b1;
          reqPrev[c] <= 1'b1;
        end else begin
          reqMeta[c] <= reqPins[c];
          reqSync[c] <= reqMeta[c];
          reqPrev[c] <= reqSync[c];
        end
      end
      // Edge latch; a new edge wins over the clear at byte start.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          edgePend[c] <= 1'b0;
        end else begin
          edgePend[c] <= (reqPrev[c] && !reqSync[c]) ||
                         (edgePend[c] && !(nextByte && (next_channel == c)));
        end
      end
      // Upper sense bit is channel 0.
      assign reqOk[c] = cfg.requestSenseSelect[1 - c] ? edgePend[c] : !reqSync[c];
    end
  endgenerate

  // Memory copy ignores the request; I/O mode waits for it.
  assign go0 = ch0Enable && (count0 != COUNT_RESET) && !isReserved && (!ch0Io || reqOk[0]);
  // Channel 1 always paced by its request.
  assign go1 = ch1Enable && (count1 != COUNT_RESET) && reqOk[1];

  // Byte length grows by the wait states of both bus cycles.
  assign byteLen = BYTE_BASE_CYCLES + {2'b00, cfg.memoryWaitCount} +
                   ((activeChannel || ch0Io) ? {2'b00, cfg.ioWaitCount}
                                             : {2'b00, cfg.memoryWaitCount});

  assign byteEnd  = (state == ST_MOVE) && (beat == byteLen - 4'h1);
  assign lastByte = activeChannel ? (count1 == 8'h01) : (count0 == 8'h01);

  // Next-state logic; channel 0 has priority over channel 1.
  always_comb begin
    next_state   = state;
    next_channel = activeChannel;
    nextByte     = 1'b0;
    case (state)
      ST_IDLE: begin
        if (go0) begin
          next_state   = ST_MOVE;
          next_channel = 1'b0;
          nextByte     = 1'b1;
        end else if (go1) begin
          next_state   = ST_MOVE;
          next_channel = 1'b1;
          nextByte     = 1'b1;
        end
      end
      ST_MOVE: begin
        if (byteEnd) begin
          if (lastByte) begin
            // Count has run out, so the bus is released.
            next_state = ST_IDLE;
          end else if (!activeChannel && !ch0Io) begin
            // Burst keeps going; cycle steal yields.
            if (cfg.memcopyTimingSelect) begin
              nextByte = 1'b1;
            end else begin
              next_state = ST_STEAL;
            end
          end else if (reqOk[activeChannel]) begin
            // Request still present at the sampling point.
            nextByte = 1'b1;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_STEAL: begin
        // One machine cycle for the processor, then resume.
        if (beat == MACHINE_CYCLES - 4'h1) begin
          if (go0) begin
            next_state = ST_MOVE;
            nextByte   = 1'b1;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers and status outputs.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state         <= ST_IDLE;
      activeChannel <= 1'b0;
      busHold       <= 1'b0;
      byteDone      <= 1'b0;
      beat          <= 4'h0;
      reservedMode  <= 1'b0;
    end else begin
      state         <= next_state;
      activeChannel <= next_channel;
      busHold       <= (next_state == ST_MOVE);
      byteDone      <= byteEnd;
      reservedMode  <= isReserved;
      // The beat restarts at each byte so waits count from the byte start.
      if (nextByte || (next_state != state)) begin
        beat <= 4'h0;
      end else begin
        beat <= beat + 4'h1;
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg.ch0DestinationSelect <= MODE_FIELD_RESET;
      cfg.ch0SourceSelect      <= MODE_FIELD_RESET;
      cfg.memcopyTimingSelect  <= 1'b0;
      // Longest waits until software speeds the bus up.
      cfg.memoryWaitCount      <= WAIT_RESET;
      cfg.ioWaitCount          <= WAIT_RESET;
      cfg.requestSenseSelect   <= MODE_FIELD_RESET;
      cfg.ch1DirectionSelect   <= MODE_FIELD_RESET;
    end else begin
      // Only the defined mode fields are stored.
      if (wrMode) begin
        cfg.ch0DestinationSelect <= regWrData[DST_LSB +: 2];
        cfg.ch0SourceSelect      <= regWrData[SRC_LSB +: 2];
        cfg.memcopyTimingSelect  <= regWrData[TIMING_BIT];
      end
      if (wrCtrl) begin
        cfg.memoryWaitCount    <= regWrData[MEMWAIT_LSB +: 2];
        cfg.ioWaitCount        <= regWrData[IOWAIT_LSB +: 2];
        cfg.requestSenseSelect <= regWrData[SENSE_LSB +: 2];
        cfg.ch1DirectionSelect <= regWrData[DIR_LSB +: 2];
      end
    end
  end

  // Enables and counts; a software write in the same cycle overrides hardware.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ch0Enable <= 1'b0;
      ch1Enable <= 1'b0;
      count0    <= COUNT_RESET;
      count1    <= COUNT_RESET;
    end else begin
      // Final byte drops the enable of its channel.
      if (byteEnd && !activeChannel) begin
        count0    <= count0 - 8'h01;
        ch0Enable <= ch0Enable && !lastByte;
      end
      if (byteEnd && activeChannel) begin
        count1    <= count1 - 8'h01;
        ch1Enable <= ch1Enable && !lastByte;
      end
      if (wrEnable) begin
        ch0Enable <= regWrData[EN0_BIT];
        ch1Enable <= regWrData[EN1_BIT];
      end
      if (regWrite && (regAddr == COUNT0_ADDR)) begin
        count0 <= regWrData;
      end
      if (regWrite && (regAddr == COUNT1_ADDR)) begin
        count1 <= regWrData;
      end
    end
  end

  // Read data, valid only in the cycle after the read strobe.
  always_ff @(posedge clk_sys) begin
    if (rst || !regRead) begin
      regRdData <= 8'h00;
    end else begin
      case (regAddr)
        MODE_ADDR:   regRdData <= {2'b00, cfg.ch0DestinationSelect, cfg.ch0SourceSelect,
                                   cfg.memcopyTimingSelect, 1'b0};
        CTRL_ADDR:   regRdData <= {cfg.memoryWaitCount, cfg.ioWaitCount,
                                   cfg.requestSenseSelect, cfg.ch1DirectionSelect};
        ENABLE_ADDR: regRdData <= {6'h00, ch1Enable, ch0Enable};
        COUNT0_ADDR: regRdData <= count0;
        COUNT1_ADDR: regRdData <= count1;
        default:     regRdData <= 8'h00;
      endcase
    end
  end

  property p_reserved_blocks;
    @(posedge clk_sys) disable iff (rst)
    (state == ST_IDLE && isReserved && !go1) |=> !busHold;
  endproperty
  a_reserved_blocks: assert property (p_reserved_blocks) else $error("reserved mode ran");

  property p_burst_holds;
    @(posedge clk_sys) disable iff (rst)
    (byteEnd && !lastByte && !activeChannel && !ch0Io && cfg.memcopyTimingSelect)
      |=> busHold && byteDone;
  endproperty
  a_burst_holds: assert property (p_burst_holds) else $error("burst released bus");

  property p_steal_gap;
    @(posedge clk_sys) disable iff (rst)
    (byteEnd && !lastByte && !activeChannel && !ch0Io && !cfg.memcopyTimingSelect)
      |=> !busHold [*3];
  endproperty
  a_steal_gap: assert property (p_steal_gap) else $error("steal gap wrong");

  property p_memcopy_start;
    @(posedge clk_sys) disable iff (rst)
    (state == ST_IDLE && ch0Enable && count0 != 8'h00 && !isReserved && !ch0Io)
      |=> busHold && !activeChannel;
  endproperty
  a_memcopy_start: assert property (p_memcopy_start) else $error("memcopy not started");

  property p_zero_clears;
    @(posedge clk_sys) disable iff (rst)
    (byteEnd && lastByte && !activeChannel && !regWrite)
      |=> !ch0Enable ##1 (!busHold || activeChannel);
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("enable not cleared");

  property p_mode_read;
    @(posedge clk_sys) disable iff (rst)
    (regRead && regAddr == MODE_ADDR) |=> regRdData[7:6] == 2'b00 && !regRdData[0];
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("unused mode bits set");

  property p_wait_reset;
    @(posedge clk_sys) disable iff (rst)
    ($past(rst) && !$past(regWrite)) |-> cfg.memoryWaitCount == 2'h3 && cfg.ioWaitCount == 2'h3;
  endproperty
  a_wait_reset: assert property (p_wait_reset) else $error("wait reset wrong");

  property p_level_release;
    @(posedge clk_sys) disable iff (rst)
    (byteEnd && !lastByte && !activeChannel && ch0Io && !cfg.requestSenseSelect[1] && reqSync[0])
      |=> !busHold;
  endproperty
  a_level_release: assert property (p_level_release) else $error("level hold wrong");

  property p_edge_wait;
    @(posedge clk_sys) disable iff (rst)
    (state == ST_IDLE && ch0Io && cfg.requestSenseSelect[1] && !edgePend[0] && !go1)
      |=> !busHold;
  endproperty
  a_edge_wait: assert property (p_edge_wait) else $error("edge start wrong");

endmodule : dma_mode_and_wait_control

// ### sim/dma_mode_and_wait_control_tb.sv
// Self-checking bench for the DMA mode, wait-state and request-sense block.
`timescale 1ns/1ps
module dma_mode_and_wait_control_tb;
  import dma_mode_pkg::*;
  logic       clk_sys   = 1'b0;   // System clock, 8 ns period.
  logic       rst       = 1'b1;   // Synchronous reset, active high.
  logic [7:0] regAddr   = 8'h00;  // Register address.
  logic [7:0] regWrData = 8'h00;  // Register write data.
  logic       regWrite  = 1'b0;   // Write strobe.
  logic       regRead   = 1'b0;   // Read strobe.
  logic [7:0] regRdData;          // Read data, one cycle after the strobe.
  logic       reqCh0_n;           // Channel 0 request pin from the model.
  logic       reqCh1_n;           // Channel 1 request pin from the model.
  logic [1:0] levelReq  = 2'h0;   // Level request commands to the model.
  logic [1:0] pulseReq  = 2'h0;   // Edge request commands to the model.
  cfg_type    cfg;                // Stored configuration bundle.
  logic       busHold;            // Engine owns the bus.
  logic       byteDone;           // End of one byte transfer.
  logic       activeChannel;      // Channel of the last transfer.
  logic       reservedMode;       // Channel 0 code pair is reserved.
  int         n_mismatch  = 0;    // Mismatches seen.
  int         check_count = 0;    // Comparisons made.
  logic [7:0] rd;                 // Last value read back.

  always #4 clk_sys = ~clk_sys;

  dma_mode_and_wait_control DUT (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .ch0RequestIn_n(reqCh0_n), .ch1RequestIn_n(reqCh1_n), .cfg(cfg), .busHold(busHold),
    .byteDone(byteDone), .activeChannel(activeChannel), .reservedMode(reservedMode));

  dma_request_source PARTNER (.clk_sys(clk_sys), .levelReq(levelReq), .pulseReq(pulseReq),
    .reqCh0_n(reqCh0_n), .reqCh1_n(reqCh1_n));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  // Compares an eight-bit design value, unknowns never match.
  task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  // Compares a count gathered by the bench while watching the outputs.
  task automatic check_num(input string name, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_num

  // One write cycle on the register port.
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    regWrite  <= 1'b1;
    regAddr   <= addr;
    regWrData <= data;
    @(posedge clk_sys);
    regWrite  <= 1'b0;
  endtask : reg_write

  // One read cycle; the data stand only in the following cycle.
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= addr;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    data = regRdData;
  endtask : reg_read

  // Read and compare in one call.
  task automatic read_check(input string name, input logic [7:0] addr, input logic [7:0] exp);
    reg_read(addr, rd);
    check_val(name, exp, rd);
  endtask : read_check

  // Watches the bus-hold and byte-done outputs for a window of cycles.
  task automatic measure(input int n, input int expHold, input int expRise, input int expDone);
    int   hold;
    int   rises;
    int   dones;
    logic prev;
    hold  = 0;
    rises = 0;
    dones = 0;
    prev  = 1'b0;
    repeat (n) begin
      @(negedge clk_sys);
      if (busHold === 1'b1) hold++;
      if (busHold === 1'b1 && !prev) rises++;
      if (byteDone === 1'b1) dones++;
      prev = (busHold === 1'b1);
    end
    check_num("busHold cycles", expHold, hold);
    check_num("busHold grants", expRise, rises);
    check_num("byteDone pulses", expDone, dones);
  endtask : measure

  // Programs both mode registers, a byte count and an enable, then watches the run.
  task automatic xfer(input logic [7:0] ctrl, input logic [7:0] mode, input logic [7:0] cnt,
                      input logic [7:0] en, input int expHold, input int expRise,
                      input int expDone);
    reg_write(CTRL_ADDR, ctrl);
    reg_write(MODE_ADDR, mode);
    reg_write((en == 8'h01) ? COUNT0_ADDR : COUNT1_ADDR, cnt);
    reg_write(ENABLE_ADDR, en);
    measure(40, expHold, expRise, expDone);
  endtask : xfer

  // A hang counts as a mismatch and ends the run through the same closing task.
  initial begin
    #(5000 * 8);
    n_mismatch++;
    tally_and_finish;
  end

  // Main sequence.
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    read_check("mode reset", MODE_ADDR, 8'h00);
    read_check("ctrl reset", CTRL_ADDR, 8'hF0);
    read_check("enable reset", ENABLE_ADDR, 8'h00);
    check_val("memWait reset", 8'h03, {6'h0, cfg.memoryWaitCount});
    check_val("ioWait reset", 8'h03, {6'h0, cfg.ioWaitCount});
    reg_write(8'h40, 8'hA5);
    read_check("unmapped", 8'h40, 8'h00);
    reg_write(MODE_ADDR, 8'hFF);
    read_check("mode unused bits", MODE_ADDR, 8'h3E);
    check_val("timing", 8'h01, {7'h0, cfg.memcopyTimingSelect});
    // Every destination and source code, reserved pairs flagged.
    for (int i = 0; i < 16; i++) begin
      reg_write(MODE_ADDR, {2'h0, i[3:0], 2'h0});
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check_val("dest", {6'h0, i[3:2]}, {6'h0, cfg.ch0DestinationSelect});
      check_val("src", {6'h0, i[1:0]}, {6'h0, cfg.ch0SourceSelect});
      check_val("reserved", {7'h0, i[3] & i[1]}, {7'h0, reservedMode});
    end
    // Every code in every field of the control register.
    for (int i = 0; i < 4; i++) begin
      reg_write(CTRL_ADDR, {4{i[1:0]}});
      read_check("ctrl", CTRL_ADDR, {4{i[1:0]}});
      check_val("dir", {6'h0, i[1:0]}, {6'h0, cfg.ch1DirectionSelect});
      check_val("sense", {6'h0, i[1:0]}, {6'h0, cfg.requestSenseSelect});
    end
    xfer(8'h00, 8'h02, 8'h02, 8'h01, 6, 1, 2);
    read_check("enable cleared", ENABLE_ADDR, 8'h00);
    xfer(8'h00, 8'h00, 8'h02, 8'h01, 6, 2, 2);
    xfer(8'h40, 8'h02, 8'h01, 8'h01, 5, 1, 1);
    xfer(8'h00, 8'h28, 8'h01, 8'h01, 0, 0, 0);
    reg_write(ENABLE_ADDR, 8'h00);
    // An I/O end waits for its request and ignores the timing bit.
    xfer(8'h00, 8'h30, 8'h02, 8'h01, 0, 0, 0);
    levelReq <= 2'h1;
    measure(40, 6, 1, 2);
    levelReq <= 2'h0;
    // Edge sense: one falling edge moves one byte only.
    xfer(8'h08, 8'h30, 8'h02, 8'h01, 0, 0, 0);
    pulseReq <= 2'h1;
    @(posedge clk_sys);
    pulseReq <= 2'h0;
    measure(40, 3, 1, 1);
    read_check("count after edge", COUNT0_ADDR, 8'h01);
    pulseReq <= 2'h1;
    @(posedge clk_sys);
    pulseReq <= 2'h0;
    measure(40, 3, 1, 1);
    read_check("enable after edges", ENABLE_ADDR, 8'h00);
    // Channel 1 I/O to memory with two I/O wait states.
    levelReq <= 2'h2;
    xfer(8'h22, 8'h00, 8'h01, 8'h02, 5, 1, 1);
    check_val("channel", 8'h01, {7'h0, activeChannel});
    levelReq <= 2'h0;
    // Channel 1 edge sense: the rising release above must not start it.
    xfer(8'h04, 8'h00, 8'h01, 8'h02, 0, 0, 0);
    pulseReq <= 2'h2;
    @(posedge clk_sys);
    pulseReq <= 2'h0;
    measure(40, 3, 1, 1);
    read_check("ch1 enable", ENABLE_ADDR, 8'h00);
    tally_and_finish;
  end
endmodule : dma_mode_and_wait_control_tb

// ### sim/dma_request_source.sv
// Request source model standing in for the I/O devices that pace DMA transfers.
`timescale 1ns/1ps
module dma_request_source (
  // Clock.
  input  wire logic       clk_sys,
  // Commands from the bench, bit 0 for channel 0 and bit 1 for channel 1.
  input  wire logic [1:0] levelReq,
  input  wire logic [1:0] pulseReq,
  // Request pins, active low, idle high as if pulled up.
  output logic            reqCh0_n,
  output logic            reqCh1_n
);
  logic [2:0] stretch0 = 3'h0;  // Remaining low cycles of a channel 0 pulse.
  logic [2:0] stretch1 = 3'h0;  // Remaining low cycles of a channel 1 pulse.

  // single falling edge
  // A pulse holds the pin low four cycles so the two-flop synchroniser cannot miss it.
  always_ff @(posedge clk_sys) begin
    stretch0 <= pulseReq[0] ? 3'h4 : ((stretch0 != 3'h0) ? stretch0 - 3'h1 : 3'h0);
    stretch1 <= pulseReq[1] ? 3'h4 : ((stretch1 != 3'h0) ? stretch1 - 3'h1 : 3'h0);
  end

  // level request low
  // A device that has nothing to move lets the pin return high at once.
  assign reqCh0_n = ~(levelReq[0] | (stretch0 != 3'h0));
  assign reqCh1_n = ~(levelReq[1] | (stretch1 != 3'h0));
endmodule : dma_request_source
